// File: common/err_alarm_pkg.sv
// Constants, register map and carrier types for the position error alarm check.
package err_alarm_pkg;

    // ------------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_ALARM_LEVEL = 8'h04;
    localparam logic [7:0] OFS_WARN_LEVEL  = 8'h08;
    localparam logic [7:0] OFS_MOTOR_PPR   = 8'h0C;
    localparam logic [7:0] OFS_LOAD_PPR    = 8'h10;
    localparam logic [7:0] OFS_LIN_NUM     = 8'h14;
    localparam logic [7:0] OFS_LIN_DEN     = 8'h18;
    localparam logic [7:0] OFS_STATUS      = 8'h1C;
    localparam logic [7:0] OFS_MARGIN      = 8'h20;
    localparam logic [7:0] OFS_THRESHOLD   = 8'h24;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h2C;
    localparam logic [7:0] OFS_ALARM_CLR   = 8'h30;

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int CTRL_W         = 5;
    localparam int BIT_ALARM      = 0;
    localparam int BIT_WARNING    = 1;
    localparam int IRQ_W          = 2;

    // ------------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------------
    localparam logic [31:0] RST_LEVEL     = 32'h0000_0000;
    localparam logic [31:0] RST_MOTOR_PPR = 32'h0004_0000;
    localparam logic [31:0] RST_LOAD_PPR  = 32'h0004_0000;
    localparam logic [31:0] RST_LIN_NUM   = 32'h0000_0001;
    localparam logic [31:0] RST_LIN_DEN   = 32'h0000_0001;
    localparam logic [31:0] RST_MAX       = 32'hFFFF_FFFF;

    // ------------------------------------------------------------------------
    // Threshold figures
    // ------------------------------------------------------------------------
    localparam logic [31:0] CLAMP_REV     = 32'h0000_00C8;
    localparam logic [31:0] DEFAULT_REV   = 32'h0000_0003;
    localparam logic [31:0] DEFAULT_MM    = 32'h0000_0064;
    localparam logic [31:0] LIN_PPR_MUL   = 32'h0000_03E8;
    localparam logic [31:0] DIV_UNIT      = 32'h0000_0001;
    localparam logic [31:0] DIV_TENTH     = 32'h0000_000A;
    localparam logic [31:0] DIV_HUNDREDTH = 32'h0000_0064;
    localparam logic [31:0] DIV_THOUSANDTH = 32'h0000_03E8;

    typedef enum logic [1:0] {
        UNIT_WHOLE      = 2'b00,
        UNIT_TENTH      = 2'b01,
        UNIT_HUNDREDTH  = 2'b10,
        UNIT_THOUSANDTH = 2'b11
    } unit_sel_t;

    typedef struct packed {
        logic      full_closed;
        logic      linear;
        logic      pos_mode;
        unit_sel_t threshold_unit_select;
    } ctrl_t;

endpackage

// File: src/position_error_alarm_check.sv
// Excessive position error alarm check with APB registers and interrupt.
//
// Overview of operation
// - Alarm when position gap reaches trigger level.
// - Rotary level in revolutions, clamped at 200.
// - Linear motor level is taken in millimetres.
// - Zero level selects 3 rev or 100 mm.
// - Unit select gives whole, tenth, hundredth, thousandth.
// - Warning level shares the same unit scale.
// - Scale applies only in position modes.
// - Margin is largest when positions coincide.
// - Alarm asserts when margin reaches zero pulses.
// - Fully closed loop uses load encoder resolution.
// - Linear encoder resolution is numerator/denominator times 1000.
`timescale 1ns/1ps
`default_nettype none

module position_error_alarm_check #(
    parameter int P_POS_W  = 32,
    parameter int P_ADDR_W = 8
) (
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [P_ADDR_W-1:0] paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [P_POS_W-1:0]  i_cmd_pos,
    input  wire logic [P_POS_W-1:0]  i_fb_pos,
    output logic                     o_excess_error_alarm,
    output logic                     o_warning,
    output logic      [31:0]         o_margin,
    output logic                     o_irq
);

    // Refuse widths that the address decode or the 33-bit gap cannot serve.
    if (P_POS_W < 16 || P_POS_W > 32 || P_ADDR_W < 8 || P_ADDR_W > 32) begin : g_bad_params
        $error("position_error_alarm_check: unsupported parameter values");
    end

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    function automatic logic [31:0] unit_div(input err_alarm_pkg::ctrl_t c);
        logic [31:0] d;
        d = err_alarm_pkg::DIV_UNIT;
        if (c.pos_mode) begin
            unique case (c.threshold_unit_select)
                err_alarm_pkg::UNIT_WHOLE:      d = err_alarm_pkg::DIV_UNIT;
                err_alarm_pkg::UNIT_TENTH:      d = err_alarm_pkg::DIV_TENTH;
                err_alarm_pkg::UNIT_HUNDREDTH:  d = err_alarm_pkg::DIV_HUNDREDTH;
                err_alarm_pkg::UNIT_THOUSANDTH: d = err_alarm_pkg::DIV_THOUSANDTH;
            endcase
        end
        return d;
    endfunction

    // The 64-bit quotient is saturated so a huge level never wraps to a small one.
    function automatic logic [31:0] to_pulses(input logic [31:0] n, input logic [31:0] ppr,
                                              input logic [31:0] d);
        logic [63:0] q;
        q = ({32'h0000_0000, n} * {32'h0000_0000, ppr}) / {32'h0000_0000, d};
        return (q[63:32] != 32'h0000_0000) ? err_alarm_pkg::RST_MAX : q[31:0];
    endfunction

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    err_alarm_pkg::ctrl_t ctrl_r;
    logic [31:0]          alarm_level_r;
    logic [31:0]          warn_level_r;
    logic [31:0]          motor_ppr_r;
    logic [31:0]          load_ppr_r;
    logic [31:0]          lin_num_r;
    logic [31:0]          lin_den_r;
    logic [err_alarm_pkg::IRQ_W-1:0] irq_stat_r;
    logic [err_alarm_pkg::IRQ_W-1:0] irq_mask_r;
    logic [err_alarm_pkg::IRQ_W-1:0] irq_set;
    logic                 alarm_r;
    logic                 warning_r;
    logic [31:0]          margin_r;
    logic [31:0]          thr_r;
    logic                 wr_en;
    logic                 rd_en;
    logic                 clr_hit;
    logic [7:0]           addr8;
    logic                 mapped;
    logic [31:0]          rd_mux;

    // A write lands only at the edge where pready is seen high, as the master expects.
    assign addr8   = paddr[7:0];
    assign wr_en   = psel && penable && pready && pwrite;
    assign rd_en   = psel && penable && !pready;
    assign clr_hit = wr_en && (addr8 == err_alarm_pkg::OFS_ALARM_CLR) && pwdata[0];

    // Offsets beyond the last register or off a word boundary answer with an error.
    always_comb begin
        mapped = (paddr[P_ADDR_W-1:2] <= P_ADDR_W'(err_alarm_pkg::OFS_ALARM_CLR) >> 2)
                 && (addr8[1:0] == 2'b00);
        rd_mux = 32'h0000_0000;
        unique case (addr8)
            err_alarm_pkg::OFS_CTRL:        rd_mux = {27'h000_0000, ctrl_r};
            err_alarm_pkg::OFS_ALARM_LEVEL: rd_mux = alarm_level_r;
            err_alarm_pkg::OFS_WARN_LEVEL:  rd_mux = warn_level_r;
            err_alarm_pkg::OFS_MOTOR_PPR:   rd_mux = motor_ppr_r;
            err_alarm_pkg::OFS_LOAD_PPR:    rd_mux = load_ppr_r;
            err_alarm_pkg::OFS_LIN_NUM:     rd_mux = lin_num_r;
            err_alarm_pkg::OFS_LIN_DEN:     rd_mux = lin_den_r;
            err_alarm_pkg::OFS_STATUS:      rd_mux = {30'h0000_0000, warning_r, alarm_r};
            err_alarm_pkg::OFS_MARGIN:      rd_mux = margin_r;
            err_alarm_pkg::OFS_THRESHOLD:   rd_mux = thr_r;
            err_alarm_pkg::OFS_IRQ_STATUS:  rd_mux = {30'h0000_0000, irq_stat_r};
            err_alarm_pkg::OFS_IRQ_MASK:    rd_mux = {30'h0000_0000, irq_mask_r};
            default:                        rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises in the second access cycle, from a flip-flop.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_en;
            pslverr <= rd_en && (paddr[P_ADDR_W-1:2] > P_ADDR_W'(err_alarm_pkg::OFS_ALARM_CLR) >> 2
                                 || !mapped);
            prdata  <= (rd_en && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
        end
    end

    // Read-only offsets and unmapped offsets below 0x100 fall through; only paddr[7:0] is decoded, so higher offsets write their alias.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ctrl_r        <= '0;
            alarm_level_r <= err_alarm_pkg::RST_LEVEL;
            warn_level_r  <= err_alarm_pkg::RST_LEVEL;
            motor_ppr_r   <= err_alarm_pkg::RST_MOTOR_PPR;
            load_ppr_r    <= err_alarm_pkg::RST_LOAD_PPR;
            lin_num_r     <= err_alarm_pkg::RST_LIN_NUM;
            lin_den_r     <= err_alarm_pkg::RST_LIN_DEN;
            irq_mask_r    <= '0;
        end else if (wr_en) begin
            unique case (addr8)
                err_alarm_pkg::OFS_CTRL:        ctrl_r <= pwdata[err_alarm_pkg::CTRL_W-1:0];
                err_alarm_pkg::OFS_ALARM_LEVEL: alarm_level_r <= pwdata;
                err_alarm_pkg::OFS_WARN_LEVEL:  warn_level_r <= pwdata;
                err_alarm_pkg::OFS_MOTOR_PPR:   motor_ppr_r <= pwdata;
                err_alarm_pkg::OFS_LOAD_PPR:    load_ppr_r <= pwdata;
                err_alarm_pkg::OFS_LIN_NUM:     lin_num_r <= pwdata;
                err_alarm_pkg::OFS_LIN_DEN:     lin_den_r <= pwdata;
                err_alarm_pkg::OFS_IRQ_MASK:    irq_mask_r <= pwdata[err_alarm_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Stage 1: effective level, scale and resolution
    // ------------------------------------------------------------------------
    logic [31:0] div_nxt;
    logic [31:0] level_nxt;
    logic [31:0] level_n_r;
    logic [31:0] warn_n_r;
    logic [31:0] div_r;
    logic [31:0] ppr_r;
    logic [31:0] ppr_nxt;
    logic [63:0] lin_ppr;
    logic        linear_r;

    always_comb begin
        div_nxt   = unit_div(ctrl_r);
        level_nxt = alarm_level_r;
        if (alarm_level_r == 32'h0000_0000) begin
            div_nxt   = err_alarm_pkg::DIV_UNIT;
            level_nxt = ctrl_r.linear ? err_alarm_pkg::DEFAULT_MM : err_alarm_pkg::DEFAULT_REV;
        end else if (!ctrl_r.linear && alarm_level_r >= 32'(err_alarm_pkg::CLAMP_REV * div_nxt)) begin
            level_nxt = 32'(err_alarm_pkg::CLAMP_REV * div_nxt);
        end
        // Linear motors keep the level in millimetres and use pulses per mm.
        lin_ppr = ({32'h0000_0000, lin_num_r} * {32'h0000_0000, err_alarm_pkg::LIN_PPR_MUL})
                  / {32'h0000_0000, (lin_den_r == 32'h0000_0000) ? 32'h0000_0001 : lin_den_r};
        if (ctrl_r.full_closed) begin
            ppr_nxt = load_ppr_r;
        end else if (ctrl_r.linear) begin
            ppr_nxt = (lin_ppr[63:32] != 32'h0000_0000) ? err_alarm_pkg::RST_MAX
                                                         : lin_ppr[31:0];
        end else begin
            ppr_nxt = motor_ppr_r;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            // Reset values equal what a zero level gives, so the stage starts consistent.
            level_n_r <= err_alarm_pkg::DEFAULT_REV;
            warn_n_r  <= err_alarm_pkg::RST_LEVEL;
            div_r     <= err_alarm_pkg::DIV_UNIT;
            ppr_r     <= err_alarm_pkg::RST_MOTOR_PPR;
            linear_r  <= 1'b0;
        end else begin
            level_n_r <= level_nxt;
            warn_n_r  <= warn_level_r;
            div_r     <= div_nxt;
            ppr_r     <= ppr_nxt;
            linear_r  <= ctrl_r.linear;
        end
    end

    // ------------------------------------------------------------------------
    // Stage 2 and 3: thresholds, gap and margin
    // ------------------------------------------------------------------------
    logic [31:0]  warn_thr_r;
    logic [31:0]  absdiff_r;
    logic [32:0]  diff;
    logic [32:0]  absdiff;
    logic [31:0]  margin_nxt;

    always_comb begin
        // Sign extension to 33 bits keeps the difference exact for any two positions.
        diff    = 33'($signed(i_cmd_pos)) - 33'($signed(i_fb_pos));
        absdiff = diff[32] ? 33'(-diff) : diff;
        margin_nxt = (absdiff_r >= thr_r) ? 32'h0000_0000 : 32'(thr_r - absdiff_r);
    end

    // The gap saturates at the top of the word rather than wrapping to a small value.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            thr_r      <= err_alarm_pkg::RST_MAX;
            warn_thr_r <= err_alarm_pkg::RST_MAX;
            absdiff_r  <= 32'h0000_0000;
            margin_r   <= err_alarm_pkg::RST_MAX;
        end else begin
            thr_r      <= to_pulses(level_n_r, ppr_r, div_r);
            warn_thr_r <= to_pulses(warn_n_r, ppr_r, div_r);
            absdiff_r  <= absdiff[32] ? err_alarm_pkg::RST_MAX : absdiff[31:0];
            margin_r   <= margin_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Alarm, warning and interrupt
    // ------------------------------------------------------------------------
    // A zero margin beats a clear in the same cycle, so a clear cannot hide a live fault.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            alarm_r <= 1'b0;
        end else if (margin_r == 32'h0000_0000) begin
            alarm_r <= 1'b1;
        end else if (clr_hit) begin
            alarm_r <= 1'b0;
        end
    end

    // A zero warning level leaves the warning disabled.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            warning_r <= 1'b0;
        end else begin
            warning_r <= (warn_n_r != 32'h0000_0000) && (absdiff_r >= warn_thr_r);
        end
    end

    // Each onset sets one status bit; the mask register shares the same layout.
    assign irq_set[err_alarm_pkg::BIT_ALARM]   = (margin_r == 32'h0000_0000) && !alarm_r;
    assign irq_set[err_alarm_pkg::BIT_WARNING] = (warn_n_r != 32'h0000_0000)
                                                 && (absdiff_r >= warn_thr_r) && !warning_r;

    // Set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            irq_stat_r <= '0;
        end else if (wr_en && addr8 == err_alarm_pkg::OFS_IRQ_STATUS) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[err_alarm_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    // The interrupt is registered, so it trails the status bits by one cycle.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign o_excess_error_alarm = alarm_r;
    assign o_warning            = warning_r;
    assign o_margin             = margin_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // Every check runs on the one clock and is quiet while reset is held.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_alarm_on_zero: assert property ((margin_r == 32'h0000_0000) |=> alarm_r)
        else $error("alarm not raised at zero margin");
    a_gap_to_alarm: assert property ((absdiff_r >= thr_r) && $stable(thr_r) |=> ##1 alarm_r)
        else $error("alarm missed when gap reached level");
    a_alarm_latched: assert property (alarm_r && !clr_hit |=> alarm_r)
        else $error("alarm dropped without clear");
    a_margin_peak: assert property ((absdiff_r == 32'h0000_0000) |=> margin_r == $past(thr_r))
        else $error("margin not at maximum with zero gap");
    a_margin_zero_over: assert property ((absdiff_r > thr_r) |=> margin_r == 32'h0000_0000)
        else $error("margin not zero beyond threshold");
    a_rotary_clamp: assert property (!linear_r |-> level_n_r <= 32'(err_alarm_pkg::CLAMP_REV * div_r))
        else $error("rotary level above clamp");
    a_zero_default: assert property ($past(alarm_level_r) == 32'h0000_0000 && !$past(ctrl_r.linear)
                                     |-> level_n_r == err_alarm_pkg::DEFAULT_REV && div_r == 32'h0000_0001)
        else $error("zero level did not give default");
    a_unit_pos_only: assert property (!$past(ctrl_r.pos_mode) |-> div_r == err_alarm_pkg::DIV_UNIT)
        else $error("unit scale used outside position mode");
    a_unit_hundredth: assert property ($past(ctrl_r.pos_mode) && $past(alarm_level_r) != 32'h0000_0000
                                       && $past(ctrl_r.threshold_unit_select) == err_alarm_pkg::UNIT_HUNDREDTH
                                       |-> div_r == err_alarm_pkg::DIV_HUNDREDTH)
        else $error("unit code 2 not hundredths");
    a_closed_loop_ppr: assert property ($past(ctrl_r.full_closed) |-> ppr_r == $past(load_ppr_r))
        else $error("closed loop resolution not load side");
    a_linear_ppr: assert property ($past(ctrl_r.linear) && !$past(ctrl_r.full_closed)
                                   && $past(lin_den_r) == 32'h0000_0004 && $past(lin_num_r) == 32'h0000_0002
                                   |-> ppr_r == 32'h0000_01F4)
        else $error("linear resolution formula wrong");

    c_alarm_rise: cover property (!alarm_r ##1 alarm_r);
    c_alarm_clear: cover property (alarm_r && clr_hit && margin_r != 32'h0000_0000 ##1 !alarm_r);
    c_irq: cover property (o_irq);
    c_linear_default: cover property (linear_r && level_n_r == err_alarm_pkg::DEFAULT_MM);
    c_warning_rise: cover property (!warning_r ##1 warning_r);

endmodule

`default_nettype wire

// File: test/servo_model.sv
// Behavioural servo motor and encoder that feeds back a position chasing the command.
`timescale 1ns/1ps
`default_nettype none

module servo_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic [31:0] i_cmd_pos,
    input  wire logic [31:0] i_lag,
    input  wire logic        i_slow,
    output logic      [31:0] o_fb_pos
);
    logic [31:0] target;

    assign target = i_cmd_pos - i_lag;

    // A slow motor moves one pulse a cycle, so the gap builds up after a step command.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fb_pos <= 32'h0000_0000;
        end else if (!i_slow) begin
            o_fb_pos <= target;
        end else if (o_fb_pos != target) begin
            o_fb_pos <= ($signed(target) > $signed(o_fb_pos)) ? o_fb_pos + 1 : o_fb_pos - 1;
        end
    end
endmodule
`default_nettype wire

// File: test/position_error_alarm_check_tb.sv
// Register-level testbench for the position error alarm check.
`timescale 1ns/1ps
`default_nettype none

module position_error_alarm_check_tb;
    logic        i_clock, i_rst, psel, penable, pwrite, pready, pslverr, slow, e;
    logic        o_excess_error_alarm, o_warning, o_irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, o_margin, cmd_pos, lag, fb_pos, q;
    int          bad_count, comparisons;
    logic [31:0] ctl[9] = '{0, 0, 5, 6, 7, 3, 8, 32'h10, 5};
    logic [31:0] lvl[9] = '{5, 250, 25, 25, 25, 25, 0, 2, 2500};
    logic [31:0] thr[9] = '{32'h1388, 32'h0003_0D40, 32'h09C4, 32'h00FA, 32'h0019,
                            32'h61A8, 32'h0003_0D40, 32'h0FA0, 32'h0003_0D40};

    position_error_alarm_check position_error_alarm_check_inst (
        .i_clock(i_clock), .i_rst(i_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_cmd_pos(cmd_pos), .i_fb_pos(fb_pos),
        .o_excess_error_alarm(o_excess_error_alarm), .o_warning(o_warning),
        .o_margin(o_margin), .o_irq(o_irq));

    servo_model servo_model_inst (
        .i_clock(i_clock), .i_rst(i_rst), .i_cmd_pos(cmd_pos), .i_lag(lag),
        .i_slow(slow), .o_fb_pos(fb_pos));

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            end_of_test;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    initial begin
        #(50ns * 40000);
        bad_count++;
        end_of_test;
    end

    initial begin
        i_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cmd_pos = 32'h0000_0000;
        lag = 32'h0000_0000;
        slow = 1'b0;
        bad_count = 0;
        comparisons = 0;
        tick(10);
        i_rst <= 1'b0;
        tick(5);
        rd(err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0000);
        rd(err_alarm_pkg::OFS_THRESHOLD, 32'h000C_0000);
        rd(err_alarm_pkg::OFS_MARGIN, 32'h000C_0000);
        apb(1'b0, 8'h34, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        apb(1'b1, err_alarm_pkg::OFS_MOTOR_PPR, 32'h0000_03E8);
        apb(1'b1, err_alarm_pkg::OFS_LOAD_PPR, 32'h0000_07D0);
        apb(1'b1, err_alarm_pkg::OFS_LIN_NUM, 32'h0000_0002);
        for (int k = 0; k < 9; k++) begin
            apb(1'b1, err_alarm_pkg::OFS_CTRL, ctl[k]);
            apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, lvl[k]);
            rd(err_alarm_pkg::OFS_THRESHOLD, thr[k]);
        end
        // Linear default with a 2/4 encoder ratio, then whole units in position mode.
        apb(1'b1, err_alarm_pkg::OFS_LIN_DEN, 32'h0000_0004);
        apb(1'b1, err_alarm_pkg::OFS_CTRL, 32'h0000_0008);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0000);
        rd(err_alarm_pkg::OFS_THRESHOLD, 32'h0000_C350);
        rd(err_alarm_pkg::OFS_CTRL, 32'h0000_0008);
        apb(1'b1, err_alarm_pkg::OFS_CTRL, 32'h0000_0004);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0005);
        rd(err_alarm_pkg::OFS_THRESHOLD, 32'h0000_1388);
        // Warning in tenths: level 2 gives 200 pulses, alarm level 25 gives 2500.
        apb(1'b1, err_alarm_pkg::OFS_CTRL, 32'h0000_0005);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0019);
        apb(1'b1, err_alarm_pkg::OFS_WARN_LEVEL, 32'h0000_0002);
        lag <= 32'h0000_00C8;
        tick(8);
        chk({31'h0, o_warning}, 32'h0000_0001);
        lag <= 32'h0000_00C7;
        tick(8);
        chk({31'h0, o_warning}, 32'h0000_0000);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0000);
        apb(1'b1, err_alarm_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0005);
        apb(1'b1, err_alarm_pkg::OFS_WARN_LEVEL, 32'h0000_0000);
        // The 5 rev level stays above the 4999 pulse swing, so the margin shows 1 here.
        lag <= 32'hFFFF_EC79;
        tick(8);
        chk(o_margin, 32'h0000_0001);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0000);
        // A slow motor lags a 6000 pulse step well past the 5000 pulse threshold.
        lag <= 32'h0000_0000;
        tick(8);
        slow <= 1'b1;
        cmd_pos <= 32'h0000_1770;
        tick(8);
        chk(o_margin, 32'h0000_0000);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0001);
        chk({31'h0, o_irq}, 32'h0000_0000);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_CLR, 32'h0000_0001);
        apb(1'b1, err_alarm_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        tick(2);
        chk({31'h0, o_irq}, 32'h0000_0001);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0001);
        rd(err_alarm_pkg::OFS_STATUS, 32'h0000_0001);
        rd(err_alarm_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
        rd(err_alarm_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        tick(6100);
        chk(o_margin, 32'h0000_1388);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0001);
        apb(1'b1, err_alarm_pkg::OFS_ALARM_CLR, 32'h0000_0001);
        tick(2);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0000);
        apb(1'b1, err_alarm_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        tick(2);
        chk({31'h0, o_irq}, 32'h0000_0000);
        rd(err_alarm_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        // Raise the alarm again with a 1000 pulse level, then reset in mid-run.
        apb(1'b1, err_alarm_pkg::OFS_ALARM_LEVEL, 32'h0000_0001);
        slow <= 1'b0;
        lag <= 32'h0000_07D0;
        tick(8);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0001);
        i_rst <= 1'b1;
        tick(3);
        i_rst <= 1'b0;
        tick(5);
        chk({31'h0, o_excess_error_alarm}, 32'h0000_0000);
        chk({31'h0, o_warning}, 32'h0000_0000);
        rd(err_alarm_pkg::OFS_THRESHOLD, 32'h000C_0000);
        end_of_test;
    end
endmodule
`default_nettype wire
